// ===== inc/adc_ctrl_pkg.sv
// shared constants, types and helpers for the converter control block
package adc_ctrl_pkg;

	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int RESULT_W = 10;
	localparam int CHAN_W   = 5;
	localparam int INPUTS   = 28;
	localparam int IRQ_W    = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PRIMARY   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SECONDARY = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RES_HIGH  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RES_LOW   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_COMPARE   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h18;

	// primary register fields
	localparam int BIT_COMPLETE   = 7;
	localparam int BIT_IRQ_EN     = 6;
	localparam int BIT_CONTINUOUS = 5;
	localparam int CHAN_LSB       = 0;

	// secondary register fields
	localparam int BIT_ACTIVE     = 7;
	localparam int BIT_TRIG_SEL   = 6;
	localparam int BIT_CMP_EN     = 5;
	localparam int BIT_CMP_GT     = 4;

	// interrupt status fields
	localparam int BIT_EVT_DONE   = 0;
	localparam int BIT_EVT_ABORT  = 1;

	// channel codes
	localparam logic [CHAN_W-1:0] CHAN_LAST_INPUT = 5'h1b;
	localparam logic [CHAN_W-1:0] CHAN_RESERVED   = 5'h1c;
	localparam logic [CHAN_W-1:0] CHAN_HIGH_REF   = 5'h1d;
	localparam logic [CHAN_W-1:0] CHAN_LOW_REF    = 5'h1e;
	localparam logic [CHAN_W-1:0] CHAN_DISABLE    = 5'h1f;

	// values after reset
	localparam logic [CHAN_W-1:0]   RESET_CHANNEL = CHAN_DISABLE;
	localparam logic [RESULT_W-1:0] RESET_RESULT  = 10'h000;
	localparam logic [RESULT_W-1:0] RESET_COMPARE = 10'h000;
	localparam logic [IRQ_W-1:0]    RESET_IRQ     = 2'h0;
	localparam logic [DATA_W-1:0]   RESET_RDATA   = 32'h0000_0000;

	typedef enum logic [0:0] {
		ST_IDLE    = 1'b0,
		ST_CONVERT = 1'b1
	} conv_state_e;

	// compare condition for one result
	function automatic logic compareHit(input logic [RESULT_W-1:0] result, input logic [RESULT_W-1:0] level,
		input logic greater);
		compareHit = greater ? (result >= level) : (result < level);
	endfunction

endpackage

// ===== rtl/trigger_sync.sv
// three-stage synchroniser and rising-event detector for the hardware trigger
module trigger_sync
	import adc_ctrl_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic asyncIn,
	output logic      riseEvent
);
	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	logic level_reg;
	logic agree;

	// a change counts only when stages two and three agree
	assign agree     = (stage2_reg == stage3_reg);
	assign riseEvent = agree && stage3_reg && !level_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
			level_reg  <= 1'b0;
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			level_reg  <= agree ? stage3_reg : level_reg;
		end
	end
endmodule // trigger_sync

// ===== rtl/channel_decoder.sv
// registered decode of the channel select code onto the analog selects
module channel_decoder
	import adc_ctrl_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic [CHAN_W-1:0]      channel,
	output logic      [INPUTS-1:0]      analogInputSelect,
	output logic                        highRefSelect,
	output logic                        lowRefSelect,
	output logic                        inputIsolated
);
	logic [INPUTS-1:0] inputNext;
	logic              isInput;

	assign isInput   = (channel <= CHAN_LAST_INPUT);
	assign inputNext = isInput ? (INPUTS'(1) << channel) : '0;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			analogInputSelect <= '0;
			highRefSelect     <= 1'b0;
			lowRefSelect      <= 1'b0;
			inputIsolated     <= 1'b1;
		end else begin
			analogInputSelect <= inputNext;
			highRefSelect     <= (channel == CHAN_HIGH_REF);
			lowRefSelect      <= (channel == CHAN_LOW_REF);
			inputIsolated     <= (channel == CHAN_DISABLE);
		end
	end
endmodule // channel_decoder

// ===== rtl/adc_conversion_control.sv
// conversion control of a 10-bit successive-approximation converter with APB registers
// Functional notes
// - writing the primary register aborts and restarts conversion unless channel is all ones (code restarts only when trigger select is register-write start)
// - compare off: complete flag sets at end of every conversion
// - compare on: complete flag sets only when the compare is true
// - primary write or low result read clears the complete flag
// - complete flag with interrupt enable raises the completion interrupt
// - continuous off: one conversion per write or per hardware trigger
// - continuous on: conversions repeat back to back once started
// - channel select is bits 4:0 and picks the sampled input
// - channel all ones powers the converter down and isolates the input
// - all ones during continuous mode stops without one more conversion
// - continuous off: converter drops to low power after each conversion
// - codes 0..27 inputs, 11101 high ref, 11110 low ref, 11100 reserved
// - up to 28 analog inputs addressed by channel select
// - trigger select picks register-write start or hardware trigger start
// - active bit set at start, cleared at completion or abort
// - greater select: true at or above level, else true below it
//
// Decided for this implementation: the register addresses and register access over APB.
module adc_conversion_control
	import adc_ctrl_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ADDR_W-1:0]          paddr,
	input  wire logic [DATA_W-1:0]          pwdata,
	output logic      [DATA_W-1:0]          prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       hwTriggerIn,
	input  wire logic                       convDone,
	input  wire logic [RESULT_W-1:0]        convResult,
	output logic                            convStart,
	output logic                            convAbort,
	output logic                            converterPowerOn,
	output logic      [INPUTS-1:0]          analogInputSelect,
	output logic                            highRefSelect,
	output logic                            lowRefSelect,
	output logic                            inputIsolated,
	output logic                            completeIrq,
	output logic                            irq
);
	import adc_ctrl_pkg::*;

	conv_state_e state_reg;
	conv_state_e state_next;

	logic                completeFlag_reg;
	logic                completeFlag_next;
	logic                irqEnable_reg;
	logic                continuous_reg;
	logic [CHAN_W-1:0]   channel_reg;
	logic                trigSel_reg;
	logic                cmpEnable_reg;
	logic                cmpGreater_reg;
	logic [RESULT_W-1:0] compareLevel_reg;
	logic [RESULT_W-1:0] result_reg;
	logic [IRQ_W-1:0]    irqStatus_reg;
	logic [IRQ_W-1:0]    irqStatus_next;
	logic [IRQ_W-1:0]    irqMask_reg;
	logic [DATA_W-1:0]   rdata_reg;
	logic                convStart_reg;
	logic                convAbort_reg;

	// bus decode
	logic setupPhase;
	logic accessPhase;
	logic busWrite;
	logic busRead;
	logic selPrimary;
	logic selSecondary;
	logic selResHigh;
	logic selResLow;
	logic selCompare;
	logic selIrqStat;
	logic selIrqMask;
	logic mapped;
	logic primaryWrite;
	logic lowRead;
	logic [CHAN_W-1:0] wrChannel;
	logic [DATA_W-1:0] readMux;

	assign setupPhase   = psel && !penable;
	assign accessPhase  = psel && penable;
	assign busWrite     = accessPhase && pwrite;
	assign busRead      = accessPhase && !pwrite;
	assign selPrimary   = (paddr == OFS_PRIMARY);
	assign selSecondary = (paddr == OFS_SECONDARY);
	assign selResHigh   = (paddr == OFS_RES_HIGH);
	assign selResLow    = (paddr == OFS_RES_LOW);
	assign selCompare   = (paddr == OFS_COMPARE);
	assign selIrqStat   = (paddr == OFS_IRQ_STAT);
	assign selIrqMask   = (paddr == OFS_IRQ_MASK);
	assign mapped       = selPrimary || selSecondary || selResHigh || selResLow
		|| selCompare || selIrqStat || selIrqMask;
	assign primaryWrite = busWrite && selPrimary;
	assign lowRead      = busRead && selResLow;
	assign wrChannel    = pwdata[CHAN_LSB +: CHAN_W];

	assign pready  = 1'b1;
	assign pslverr = accessPhase && !mapped;
	assign prdata  = rdata_reg;

	always_comb begin
		readMux = '0;
		unique case (1'b1)
			selPrimary: begin
				readMux[BIT_COMPLETE]              = completeFlag_reg;
				readMux[BIT_IRQ_EN]                = irqEnable_reg;
				readMux[BIT_CONTINUOUS]            = continuous_reg;
				readMux[CHAN_LSB +: CHAN_W]        = channel_reg;
			end
			selSecondary: begin
				readMux[BIT_ACTIVE]                = (state_reg == ST_CONVERT);
				readMux[BIT_TRIG_SEL]              = trigSel_reg;
				readMux[BIT_CMP_EN]                = cmpEnable_reg;
				readMux[BIT_CMP_GT]                = cmpGreater_reg;
			end
			selResHigh:  readMux[1:0]              = result_reg[RESULT_W-1:8];
			selResLow:   readMux[7:0]              = result_reg[7:0];
			selCompare:  readMux[RESULT_W-1:0]     = compareLevel_reg;
			selIrqStat:  readMux[IRQ_W-1:0]        = irqStatus_reg;
			selIrqMask:  readMux[IRQ_W-1:0]        = irqMask_reg;
			default:     readMux                   = '0;
		endcase
	end

	// hardware trigger
	logic hwRise;

	trigger_sync u_trigger_sync (
		.clock     (clock),
		.rst       (rst),
		.asyncIn   (hwTriggerIn),
		.riseEvent (hwRise)
	);

	// sequencing
	logic converting;
	logic doneEvent;
	logic chanEnabled;
	logic hit;
	logic flagSet;
	logic swStart;
	logic hwStart;
	logic repeatStart;
	logic startReq;
	logic abortEvent;

	assign converting  = (state_reg == ST_CONVERT);
	assign chanEnabled = (channel_reg != CHAN_DISABLE);
	// a primary write aborts, so a coincident completion is dropped
	assign doneEvent   = converting && convDone && !primaryWrite;
	assign hit         = compareHit(convResult, compareLevel_reg, cmpGreater_reg);
	assign flagSet     = doneEvent && (!cmpEnable_reg || hit);
	assign swStart     = primaryWrite && (wrChannel != CHAN_DISABLE) && !trigSel_reg;
	assign hwStart     = !primaryWrite && trigSel_reg && hwRise && !converting && chanEnabled;
	assign repeatStart = doneEvent && continuous_reg && chanEnabled;
	assign startReq    = swStart || hwStart || repeatStart;
	assign abortEvent  = primaryWrite && converting;

	always_comb begin
		state_next = state_reg;
		if (primaryWrite) begin
			state_next = swStart ? ST_CONVERT : ST_IDLE;
		end else if (hwStart) begin
			state_next = ST_CONVERT;
		end else if (doneEvent) begin
			state_next = repeatStart ? ST_CONVERT : ST_IDLE;
		end
	end

	// set wins over a result-low read clear
	assign completeFlag_next = flagSet ? 1'b1 : ((primaryWrite || lowRead) ? 1'b0 : completeFlag_reg);

	assign irqStatus_next = (irqStatus_reg & ~((busWrite && selIrqStat) ? pwdata[IRQ_W-1:0] : '0))
		| {abortEvent, doneEvent};

	assign convStart        = convStart_reg;
	assign convAbort        = convAbort_reg;
	assign converterPowerOn = converting;
	assign completeIrq      = completeFlag_reg && irqEnable_reg;
	assign irq              = completeIrq || |(irqStatus_reg & irqMask_reg);

	channel_decoder u_channel_decoder (
		.clock             (clock),
		.rst               (rst),
		.channel           (channel_reg),
		.analogInputSelect (analogInputSelect),
		.highRefSelect     (highRefSelect),
		.lowRefSelect      (lowRefSelect),
		.inputIsolated     (inputIsolated)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg        <= ST_IDLE;
			completeFlag_reg <= 1'b0;
			convStart_reg    <= 1'b0;
			convAbort_reg    <= 1'b0;
			irqStatus_reg    <= RESET_IRQ;
			result_reg       <= RESET_RESULT;
			rdata_reg        <= RESET_RDATA;
		end else begin
			state_reg        <= state_next;
			completeFlag_reg <= completeFlag_next;
			convStart_reg    <= startReq;
			convAbort_reg    <= abortEvent;
			irqStatus_reg    <= irqStatus_next;
			result_reg       <= flagSet ? convResult : result_reg;
			rdata_reg        <= (setupPhase && !pwrite) ? readMux : rdata_reg;
		end
	end

	// software-written control; complete flag bit not written
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irqEnable_reg    <= 1'b0;
			continuous_reg   <= 1'b0;
			channel_reg      <= RESET_CHANNEL;
		end else if (primaryWrite) begin
			irqEnable_reg    <= pwdata[BIT_IRQ_EN];
			continuous_reg   <= pwdata[BIT_CONTINUOUS];
			channel_reg      <= wrChannel;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trigSel_reg      <= 1'b0;
			cmpEnable_reg    <= 1'b0;
			cmpGreater_reg   <= 1'b0;
			compareLevel_reg <= RESET_COMPARE;
			irqMask_reg      <= RESET_IRQ;
		end else begin
			if (busWrite && selSecondary) begin
				trigSel_reg    <= pwdata[BIT_TRIG_SEL];
				cmpEnable_reg  <= pwdata[BIT_CMP_EN];
				cmpGreater_reg <= pwdata[BIT_CMP_GT];
			end
			if (busWrite && selCompare) begin
				compareLevel_reg <= pwdata[RESULT_W-1:0];
			end
			if (busWrite && selIrqMask) begin
				irqMask_reg <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// checks
	property p_write_starts;
		@(posedge clock) disable iff (rst)
		(primaryWrite && wrChannel != CHAN_DISABLE && !trigSel_reg) |-> ##1 (convStart && converterPowerOn);
	endproperty
	a_write_starts: assert property (p_write_starts) else $error("write did not start a conversion");

	property p_disable_stops;
		@(posedge clock) disable iff (rst)
		(primaryWrite && wrChannel == CHAN_DISABLE) |-> ##1 (!convStart && !converterPowerOn) ##1 inputIsolated;
	endproperty
	a_disable_stops: assert property (p_disable_stops) else $error("disable code did not stop");

	property p_flag_plain;
		@(posedge clock) disable iff (rst)
		(doneEvent && !cmpEnable_reg) |-> ##1 (completeFlag_reg && result_reg == $past(convResult));
	endproperty
	a_flag_plain: assert property (p_flag_plain) else $error("flag not set on completion");

	property p_flag_compare;
		@(posedge clock) disable iff (rst)
		(doneEvent && cmpEnable_reg && !completeFlag_reg && !hit) |-> ##1 !completeFlag_reg;
	endproperty
	a_flag_compare: assert property (p_flag_compare) else $error("flag set on false compare");

	property p_flag_clear;
		@(posedge clock) disable iff (rst)
		(primaryWrite || (lowRead && !flagSet)) |-> ##1 !completeFlag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_irq_follows;
		@(posedge clock) disable iff (rst)
		(flagSet && irqEnable_reg) |-> ##1 (completeIrq && irq);
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("completion interrupt missing");

	property p_single_idle;
		@(posedge clock) disable iff (rst)
		(doneEvent && !continuous_reg) |-> ##1 (!convStart && !converterPowerOn);
	endproperty
	a_single_idle: assert property (p_single_idle) else $error("single conversion did not stop");

	property p_continuous;
		@(posedge clock) disable iff (rst)
		(doneEvent && continuous_reg && chanEnabled) |-> ##1 (convStart && converting);
	endproperty
	a_continuous: assert property (p_continuous) else $error("continuous conversion did not repeat");

	property p_active_abort;
		@(posedge clock) disable iff (rst)
		abortEvent |-> ##1 convAbort;
	endproperty
	a_active_abort: assert property (p_active_abort) else $error("abort not signalled");

	property p_hw_start;
		@(posedge clock) disable iff (rst)
		(hwRise && trigSel_reg && !converting && chanEnabled && !primaryWrite) |-> ##1 (convStart && converting);
	endproperty
	a_hw_start: assert property (p_hw_start) else $error("hardware trigger ignored");

	property p_hw_mode_write;
		@(posedge clock) disable iff (rst)
		(primaryWrite && trigSel_reg) |-> ##1 !convStart;
	endproperty
	a_hw_mode_write: assert property (p_hw_mode_write) else $error("write started in hardware mode");

	property p_abort_idle;
		@(posedge clock) disable iff (rst)
		(abortEvent && !swStart) |-> ##1 (!converting && convAbort);
	endproperty
	a_abort_idle: assert property (p_abort_idle) else $error("active bit not cleared on abort");

	property p_result_hold;
		@(posedge clock) disable iff (rst)
		(doneEvent && cmpEnable_reg && !hit) |-> ##1 (result_reg == $past(result_reg));
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed on false compare");

	property p_decode_input;
		@(posedge clock) disable iff (rst)
		(channel_reg <= CHAN_LAST_INPUT) |-> ##1 ((analogInputSelect == (INPUTS'(1) << $past(channel_reg)))
			&& !highRefSelect && !lowRefSelect && !inputIsolated);
	endproperty
	a_decode_input: assert property (p_decode_input) else $error("input select wrong");

	property p_decode_ref;
		@(posedge clock) disable iff (rst)
		(channel_reg == CHAN_HIGH_REF || channel_reg == CHAN_LOW_REF)
			|-> ##1 ((analogInputSelect == '0) && (highRefSelect != lowRefSelect) && !inputIsolated);
	endproperty
	a_decode_ref: assert property (p_decode_ref) else $error("reference select wrong");

endmodule // adc_conversion_control

// ===== tb/adc_conversion_control_tb.sv
// self-checking bench for the converter control block
module adc_conversion_control_tb
	import adc_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [ADDR_W-1:0]     paddr = '0;
	logic [DATA_W-1:0]     pwdata = '0;
	logic [DATA_W-1:0]     prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  hwTriggerIn = 1'b0;
	logic                  convDone = 1'b0;
	logic [RESULT_W-1:0]   convResult = '0;
	logic                  convStart;
	logic                  convAbort;
	logic                  converterPowerOn;
	logic [INPUTS-1:0]     analogInputSelect;
	logic                  highRefSelect;
	logic                  lowRefSelect;
	logic                  inputIsolated;
	logic                  completeIrq;
	logic                  irq;
	logic                  s;
	logic                  a;
	logic                  lastErr;
	logic [CHAN_W-1:0]     ch;
	logic [RESULT_W-1:0]   r;
	int                    c;
	int                    miscompares = 0;
	int                    nChecks = 0;

	always #25 clock = ~clock;

	adc_conversion_control dut (
		.clock             (clock),
		.rst               (rst),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.hwTriggerIn       (hwTriggerIn),
		.convDone          (convDone),
		.convResult        (convResult),
		.convStart         (convStart),
		.convAbort         (convAbort),
		.converterPowerOn  (converterPowerOn),
		.analogInputSelect (analogInputSelect),
		.highRefSelect     (highRefSelect),
		.lowRefSelect      (lowRefSelect),
		.inputIsolated     (inputIsolated),
		.completeIrq       (completeIrq),
		.irq               (irq)
	);

	task automatic endSim();
		$display("comparisons %0d, mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			miscompares++;
			$display("unexpected at %0t: no bus answer", $time);
			endSim();
		end else begin
			q = prdata;
			lastErr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		apb(1'b1, ad, d, q);
	endtask

	task automatic rdChk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] q;
		apb(1'b0, ad, '0, q);
		check(q, exp);
	endtask

	// records start and abort pulses over a fixed window
	task automatic watch();
		s = 1'b0;
		a = 1'b0;
		repeat (12) begin
			@(posedge clock);
			if (convStart === 1'b1) s = 1'b1;
			if (convAbort === 1'b1) a = 1'b1;
		end
	endtask

	task automatic finishConv(input logic [RESULT_W-1:0] res);
		@(posedge clock);
		convDone <= 1'b1;
		convResult <= res;
		@(posedge clock);
		convDone <= 1'b0;
	endtask

	task automatic convert(input logic [7:0] ctl, input logic [RESULT_W-1:0] res);
		wr(OFS_PRIMARY, {24'h00_0000, ctl});
		watch();
		check(s, 1'b1);
		finishConv(res);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rdChk(OFS_PRIMARY, 32'h0000_001f);
		check(inputIsolated, 1'b1);
		rdChk(OFS_SECONDARY, 32'h0000_0000);
		check(lastErr, 1'b0);
		check(pready, 1'b1);
		rdChk(8'h1c, 32'h0000_0000);
		check(lastErr, 1'b1);
		$display("test reset done");

		for (c = 0; c < 32; c++) begin
			ch = c[CHAN_W-1:0];
			r = 10'(c * 33);
			wr(OFS_PRIMARY, {27'h000_0000, ch});
			watch();
			check(s, ch != CHAN_DISABLE);
			check(analogInputSelect, (c < INPUTS) ? (28'h000_0001 << c) : 28'h000_0000);
			check({highRefSelect, lowRefSelect}, {ch == CHAN_HIGH_REF, ch == CHAN_LOW_REF});
			check(inputIsolated, ch == CHAN_DISABLE);
			if (ch != CHAN_DISABLE) begin
				rdChk(OFS_SECONDARY, 32'h0000_0080);
				finishConv(r);
				@(posedge clock);
				check(converterPowerOn, 1'b0);
				rdChk(OFS_PRIMARY, {24'h00_0000, 3'b100, ch});
				rdChk(OFS_RES_HIGH, {30'h0000_0000, r[9:8]});
				rdChk(OFS_RES_LOW, {24'h00_0000, r[7:0]});
				rdChk(OFS_PRIMARY, {27'h000_0000, ch});
				watch();
				check(s, 1'b0);
			end
		end
		$display("test channels done");

		wr(OFS_IRQ_STAT, 32'h0000_0003);
		wr(OFS_PRIMARY, 32'h0000_0003);
		watch();
		wr(OFS_PRIMARY, 32'h0000_0005);
		watch();
		check({s, a}, 2'b11);
		check(analogInputSelect, 28'h000_0020);
		rdChk(OFS_IRQ_STAT, 32'h0000_0002);
		finishConv(10'h000);
		wr(OFS_IRQ_MASK, 32'h0000_0002);
		@(posedge clock);
		check(irq, 1'b1);
		wr(OFS_IRQ_STAT, 32'h0000_0002);
		@(posedge clock);
		check(irq, 1'b0);
		$display("test abort done");

		convert(8'h42, 10'h011);
		@(posedge clock);
		check({completeIrq, irq}, 2'b11);
		repeat (5) @(posedge clock);
		check(completeIrq, 1'b1);
		wr(OFS_PRIMARY, 32'h0000_00df);
		@(posedge clock);
		check({completeIrq, irq}, 2'b00);
		rdChk(OFS_PRIMARY, 32'h0000_005f);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		@(posedge clock);
		check(irq, 1'b1);
		wr(OFS_IRQ_STAT, 32'h0000_0001);
		@(posedge clock);
		check(irq, 1'b0);
		$display("test interrupt done");

		wr(OFS_COMPARE, 32'h0000_0100);
		wr(OFS_SECONDARY, 32'h0000_0020);
		convert(8'h01, 10'h1ff);
		rdChk(OFS_PRIMARY, 32'h0000_0001);
		convert(8'h01, 10'h0ff);
		rdChk(OFS_PRIMARY, 32'h0000_0081);
		wr(OFS_SECONDARY, 32'h0000_0030);
		convert(8'h01, 10'h100);
		rdChk(OFS_PRIMARY, 32'h0000_0081);
		convert(8'h01, 10'h0ff);
		rdChk(OFS_PRIMARY, 32'h0000_0001);
		$display("test compare done");

		wr(OFS_SECONDARY, 32'h0000_0000);
		convert(8'h24, 10'h055);
		watch();
		check({s, converterPowerOn}, 2'b11);
		finishConv(10'h056);
		watch();
		check(s, 1'b1);
		wr(OFS_PRIMARY, 32'h0000_003f);
		watch();
		check({s, a, converterPowerOn, inputIsolated}, 4'b0101);
		$display("test continuous done");

		wr(OFS_SECONDARY, 32'h0000_0040);
		wr(OFS_PRIMARY, 32'h0000_0002);
		watch();
		check(s, 1'b0);
		hwTriggerIn <= 1'b1;
		watch();
		check(s, 1'b1);
		finishConv(10'h077);
		watch();
		check({s, converterPowerOn}, 2'b00);
		hwTriggerIn <= 1'b0;
		repeat (4) @(posedge clock);
		hwTriggerIn <= 1'b1;
		watch();
		check(s, 1'b1);
		finishConv(10'h078);
		hwTriggerIn <= 1'b0;
		$display("test trigger done");
		endSim();
	end

endmodule // adc_conversion_control_tb
